// ===== logic/csb_params.svh
// constants for the compare, skip and branch execution unit
// assumes an 8-bit core with a 16-bit word-addressed program counter
`ifndef CSB_PARAMS_SVH
`define CSB_PARAMS_SVH

// data path widths
`define CSB_DATA_W 8
`define CSB_PC_W 16
`define CSB_K_W 7
`define CSB_SEL_W 3

// processor_flags bit positions
`define CSB_FLAG_C 0
`define CSB_FLAG_Z 1
`define CSB_FLAG_N 2
`define CSB_FLAG_V 3
`define CSB_FLAG_S 4
`define CSB_FLAG_H 5
`define CSB_FLAG_T 6
`define CSB_FLAG_I 7

// reset values
`define CSB_PC_RST 16'h0000
`define CSB_FLAGS_RST 8'h00

// program counter steps, in words
`define CSB_STEP_SEQ 16'h0001
`define CSB_STEP_SKIP1 16'h0002
`define CSB_STEP_SKIP2 16'h0003

// execution times, in clock cycles
`define CSB_CYC_ONE 2'h1
`define CSB_CYC_TWO 2'h2
`define CSB_CYC_THREE 2'h3

`endif

// ===== logic/csb_pkg.sv
// types for the compare, skip and branch execution unit
// assumes csb_params.svh is on the include path
package csb_pkg;

   // instruction selector presented by the decoder
   typedef enum logic [4:0] {
      csb_op_compare_skip_equal = 5'h00,
      csb_op_compare_regs = 5'h01,
      csb_op_compare_regs_with_carry = 5'h02,
      csb_op_compare_immediate = 5'h03,
      csb_op_skip_reg_bit_clear = 5'h04,
      csb_op_skip_reg_bit_set = 5'h05,
      csb_op_skip_io_bit_clear = 5'h06,
      csb_op_skip_io_bit_set = 5'h07,
      csb_op_branch_flag_set = 5'h08,
      csb_op_branch_flag_clear = 5'h09,
      csb_op_branch_equal = 5'h0A,
      csb_op_branch_not_equal = 5'h0B,
      csb_op_branch_carry_set = 5'h0C,
      csb_op_branch_carry_clear = 5'h0D,
      csb_op_branch_same_or_higher = 5'h0E,
      csb_op_branch_lower = 5'h0F,
      csb_op_branch_minus = 5'h10,
      csb_op_branch_plus = 5'h11,
      csb_op_branch_greater_equal_signed = 5'h12,
      csb_op_branch_less_signed = 5'h13,
      csb_op_branch_half_carry_set = 5'h14,
      csb_op_branch_half_carry_clear = 5'h15,
      csb_op_branch_transfer_bit_set = 5'h16,
      csb_op_branch_transfer_bit_clear = 5'h17,
      csb_op_branch_overflow_set = 5'h18,
      csb_op_branch_overflow_clear = 5'h19
   } csb_op_type;

   // sequencer states, gray coded
   typedef enum logic {
      csb_st_idle = 1'b0,
      csb_st_hold = 1'b1
   } csb_state_type;

endpackage

// ===== logic/csb_unit.sv
// execution unit for compare, conditional skip and conditional branch
// assumes operands and flags are stable in the cycle start_i is high
`timescale 1ns/1ps
`include "csb_params.svh"


module csb_unit (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire csb_pkg::csb_op_type op_i,
   input wire logic [`CSB_DATA_W-1:0] rd_i,
   input wire logic [`CSB_DATA_W-1:0] rr_i,
   input wire logic [`CSB_DATA_W-1:0] imm_i,
   input wire logic [`CSB_SEL_W-1:0] bit_sel_i,
   input wire logic [`CSB_DATA_W-1:0] io_val_i,
   input wire logic [`CSB_DATA_W-1:0] flags_i,
   input wire logic [`CSB_PC_W-1:0] pc_i,
   input wire logic [`CSB_K_W-1:0] k_i,
   input wire logic next_two_word_i,
   output logic [`CSB_PC_W-1:0] pc_o,
   output logic [`CSB_DATA_W-1:0] flags_o,
   output logic flags_we_o,
   output logic taken_o,
   output logic done_o,
   output logic busy_o
);
   import csb_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // helper functions

   // pick one bit of a byte
   function automatic logic bit_pick(input logic [7:0] v, input logic [2:0] s);
      bit_pick = v[s];
   endfunction

   // flags of a - b - cin as {z, n, v, c, h}; keep_z chains the zero flag
   function automatic logic [4:0] sub_flags(input logic [7:0] a, input logic [7:0] b,
                                            input logic cin, input logic z_in,
                                            input logic keep_z);
      logic [7:0] r;
      logic z;
      r = a - b - {7'h00, cin};
      z = (r == 8'h00) && (z_in || !keep_z);
      sub_flags = {z, r[7],
                   (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]),
                   (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]),
                   (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3])};
   endfunction

   // branch decode: {is_branch, condition holds}
   function automatic logic [1:0] br_decode(input csb_op_type op, input logic [7:0] f,
                                            input logic [2:0] s);
      logic nv;
      nv = f[`CSB_FLAG_N] ^ f[`CSB_FLAG_V];
      case (op)
         csb_op_branch_flag_set: br_decode = {1'b1, bit_pick(f, s)};
         csb_op_branch_flag_clear: br_decode = {1'b1, !bit_pick(f, s)};
         csb_op_branch_equal: br_decode = {1'b1, f[`CSB_FLAG_Z]};
         csb_op_branch_not_equal: br_decode = {1'b1, !f[`CSB_FLAG_Z]};
         csb_op_branch_carry_set: br_decode = {1'b1, f[`CSB_FLAG_C]};
         csb_op_branch_carry_clear: br_decode = {1'b1, !f[`CSB_FLAG_C]};
         csb_op_branch_same_or_higher: br_decode = {1'b1, !f[`CSB_FLAG_C]};
         csb_op_branch_lower: br_decode = {1'b1, f[`CSB_FLAG_C]};
         csb_op_branch_minus: br_decode = {1'b1, f[`CSB_FLAG_N]};
         csb_op_branch_plus: br_decode = {1'b1, !f[`CSB_FLAG_N]};
         csb_op_branch_greater_equal_signed: br_decode = {1'b1, !nv};
         csb_op_branch_less_signed: br_decode = {1'b1, nv};
         csb_op_branch_half_carry_set: br_decode = {1'b1, f[`CSB_FLAG_H]};
         csb_op_branch_half_carry_clear: br_decode = {1'b1, !f[`CSB_FLAG_H]};
         csb_op_branch_transfer_bit_set: br_decode = {1'b1, f[`CSB_FLAG_T]};
         csb_op_branch_transfer_bit_clear: br_decode = {1'b1, !f[`CSB_FLAG_T]};
         csb_op_branch_overflow_set: br_decode = {1'b1, f[`CSB_FLAG_V]};
         csb_op_branch_overflow_clear: br_decode = {1'b1, !f[`CSB_FLAG_V]};
         default: br_decode = 2'h0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // state and declarations

   csb_state_type state_r;
   logic [1:0] cnt_r;
   logic [`CSB_PC_W-1:0] pend_pc_r;
   logic [`CSB_DATA_W-1:0] pend_flags_r;
   logic pend_we_r;
   logic pend_taken_r;

   wire logic take = start_i && (state_r == csb_st_idle);
   wire logic is_compare_skip_equal = (op_i == csb_op_compare_skip_equal);
   wire logic is_cpc = (op_i == csb_op_compare_regs_with_carry);
   wire logic is_cpi = (op_i == csb_op_compare_immediate);
   wire logic is_cmp = (op_i == csb_op_compare_regs) || is_cpc || is_cpi;
   wire logic is_sbr = (op_i == csb_op_skip_reg_bit_clear) || (op_i == csb_op_skip_reg_bit_set);
   wire logic is_sio = (op_i == csb_op_skip_io_bit_clear) || (op_i == csb_op_skip_io_bit_set);
   wire logic is_skip = is_compare_skip_equal || is_sbr || is_sio;

   ////////////////////////////////////////////////////////////////////////////
   // decode of compare flags, skip and branch conditions

   // compare: subtract only, result discarded
   wire logic [7:0] cmp_rhs = is_cpi ? imm_i : rr_i;
   wire logic cmp_cin = is_cpc && flags_i[`CSB_FLAG_C];
   wire logic [4:0] cmp_f = sub_flags(rd_i, cmp_rhs, cmp_cin, flags_i[`CSB_FLAG_Z], is_cpc);
   wire logic [7:0] cmp_flags = {flags_i[`CSB_FLAG_I], flags_i[`CSB_FLAG_T], cmp_f[0],
                                 flags_i[`CSB_FLAG_S], cmp_f[2], cmp_f[3], cmp_f[4], cmp_f[1]};

   // skip conditions; set/clear variants differ in the low opcode bit
   wire logic reg_bit = bit_pick(rr_i, bit_sel_i);
   wire logic io_bit = bit_pick(io_val_i, bit_sel_i);
   wire logic sbr_cond = op_i[0] ? reg_bit : !reg_bit;
   wire logic sio_cond = op_i[0] ? io_bit : !io_bit;
   wire logic skip_go = (is_compare_skip_equal && (rd_i == rr_i)) || (is_sbr && sbr_cond) ||
                        (is_sio && sio_cond);

   // branch condition and relative target
   wire logic [1:0] br = br_decode(op_i, flags_i, bit_sel_i);
   wire logic br_go = br[1] && br[0];
   wire logic [`CSB_PC_W-1:0] k_ext = {{(`CSB_PC_W-`CSB_K_W){k_i[`CSB_K_W-1]}}, k_i};
   wire logic [`CSB_PC_W-1:0] br_target = pc_i + k_ext + `CSB_STEP_SEQ;

   // next pc, cycle count, and flag result
   wire logic [`CSB_PC_W-1:0] skip_step = next_two_word_i ? `CSB_STEP_SKIP2 : `CSB_STEP_SKIP1;
   wire logic [`CSB_PC_W-1:0] new_pc = (is_skip && skip_go) ? pc_i + skip_step :
                                       br_go ? br_target : pc_i + `CSB_STEP_SEQ;
   wire logic [1:0] skip_cyc = next_two_word_i ? `CSB_CYC_THREE : `CSB_CYC_TWO;
   wire logic [1:0] cyc = (is_skip && skip_go) ? skip_cyc :
                          br_go ? `CSB_CYC_TWO : `CSB_CYC_ONE;
   wire logic taken_now = (is_skip && skip_go) || br_go;
   wire logic [7:0] new_flags = is_cmp ? cmp_flags : flags_i;

   // finish now for single-cycle work, later for held work
   // counter is loaded with the full count at the taking edge and drops once per held cycle,
   // so the last held cycle is the one in which it still reads two
   wire logic fin_now = take && (cyc == `CSB_CYC_ONE);
   wire logic fin_late = (state_r == csb_st_hold) && (cnt_r == `CSB_CYC_TWO);
   wire logic fin = fin_now || fin_late;
   wire logic hold_nxt = (take && !fin_now) || ((state_r == csb_st_hold) && !fin_late);

   ////////////////////////////////////////////////////////////////////////////
   // sequencer

   // cycle counter and state
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         state_r <= csb_st_idle;
         cnt_r <= 2'h0;
      end else begin
         state_r <= hold_nxt ? csb_st_hold : csb_st_idle;
         cnt_r <= take ? cyc : (cnt_r - {1'b0, state_r == csb_st_hold});
      end
   end

   // results captured at acceptance
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         pend_pc_r <= `CSB_PC_RST;
         pend_flags_r <= `CSB_FLAGS_RST;
         pend_we_r <= 1'b0;
         pend_taken_r <= 1'b0;
      end else if (take) begin
         pend_pc_r <= new_pc;
         pend_flags_r <= new_flags;
         pend_we_r <= is_cmp;
         pend_taken_r <= taken_now;
      end
   end

   // pc, taken and flags outputs updated only when an instruction finishes; done, busy and flag write every cycle
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         pc_o <= `CSB_PC_RST;
         flags_o <= `CSB_FLAGS_RST;
         flags_we_o <= 1'b0;
         taken_o <= 1'b0;
         done_o <= 1'b0;
         busy_o <= 1'b0;
      end else begin
         done_o <= fin;
         busy_o <= hold_nxt;
         flags_we_o <= fin_now ? is_cmp : (fin_late && pend_we_r);
         if (fin) begin
            pc_o <= fin_now ? new_pc : pend_pc_r;
            taken_o <= fin_now ? taken_now : pend_taken_r;
         end
         if (fin_now && is_cmp) begin
            flags_o <= new_flags;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   compare_skip_equal_skip_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (take && is_compare_skip_equal && (rd_i == rr_i) && !next_two_word_i) |=>
      !done_o ##1 (done_o && (pc_o == $past(pc_i, 2) + `CSB_STEP_SKIP1)))
      else $error("equal compare did not skip in two cycles");

   compare_skip_equal_noskip_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (take && is_compare_skip_equal && (rd_i != rr_i)) |=>
      (done_o && !taken_o && (pc_o == $past(pc_i) + `CSB_STEP_SEQ)))
      else $error("unequal compare did not fall through");

   cmp_zero_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (take && (op_i == csb_op_compare_regs)) |=>
      (done_o && flags_we_o && (flags_o[`CSB_FLAG_Z] == ($past(rd_i) == $past(rr_i)))))
      else $error("register compare zero flag wrong");

   reg_skip_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (take && (op_i == csb_op_skip_reg_bit_set) && reg_bit && next_two_word_i) |=>
      !done_o [*2] ##1 (done_o && taken_o && (pc_o == $past(pc_i, 3) + `CSB_STEP_SKIP2)))
      else $error("set register bit did not skip two words");

   io_skip_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (take && (op_i == csb_op_skip_io_bit_clear) && io_bit) |=>
      (done_o && !taken_o))
      else $error("io bit skip taken with bit set");

   branch_taken_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (take && br_go) |=> busy_o && !done_o ##1
      (done_o && taken_o && (pc_o == $past(br_target, 2))))
      else $error("taken branch wrong target or time");

   lower_branch_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (take && (op_i == csb_op_branch_lower) && !flags_i[`CSB_FLAG_C]) |=>
      (done_o && (pc_o == $past(pc_i) + `CSB_STEP_SEQ)))
      else $error("lower branch taken on carry clear");

   signed_ge_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (take && (op_i == csb_op_branch_greater_equal_signed) &&
       (flags_i[`CSB_FLAG_N] == flags_i[`CSB_FLAG_V])) |=> ##1 (done_o && taken_o))
      else $error("signed greater-or-equal not taken");

   flags_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (done_o && !flags_we_o) |-> $stable(flags_o))
      else $error("flags changed by skip or branch");

endmodule

// ===== tb/csb_unit_test.sv
// self-checking bench for the compare, skip and branch execution unit
// assumes csb_params.svh on the include path and csb_pkg compiled first
`timescale 1ns/1ps
`include "csb_params.svh"

module csb_unit_test;
   import csb_pkg::*;

   logic mclk_i, rst_i, start_i, next_two_word_i;
   csb_op_type op_i;
   logic [7:0] rd_i, rr_i, imm_i, io_val_i, flags_i, flags_o;
   logic [2:0] bit_sel_i;
   logic [15:0] pc_i, pc_o;
   logic [6:0] k_i;
   logic flags_we_o, taken_o, done_o, busy_o;
   int n_mismatch = 0;
   int cmp_count = 0;
   logic [31:0] rng = 32'h0000_0045;
   logic [7:0] exp_flags = 8'h00;

   csb_unit csb_unit_inst (.mclk_i(mclk_i), .rst_i(rst_i), .start_i(start_i), .op_i(op_i),
      .rd_i(rd_i), .rr_i(rr_i), .imm_i(imm_i), .bit_sel_i(bit_sel_i), .io_val_i(io_val_i),
      .flags_i(flags_i), .pc_i(pc_i), .k_i(k_i), .next_two_word_i(next_two_word_i),
      .pc_o(pc_o), .flags_o(flags_o), .flags_we_o(flags_we_o), .taken_o(taken_o),
      .done_o(done_o), .busy_o(busy_o));

   ////////////////////////////////////////////////////////////////////////////////
   // xorshift source, fixed start
   function automatic logic [31:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction

   // comparisons, counted
   task automatic chk_val(input string nm, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_bit(input string nm, input logic e, input logic g);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic chk_rst();
      chk_val("pc_o", 16'h0000, pc_o);
      chk_val("flags_o", 16'h0000, {8'h00, flags_o});
      chk_bit("taken_o", 1'b0, taken_o);
      chk_bit("done_o", 1'b0, done_o);
      chk_bit("busy_o", 1'b0, busy_o);
      chk_bit("flags_we_o", 1'b0, flags_we_o);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // reference model: cycles, next pc, taken, flag write
   task automatic model(input logic [4:0] op, input logic [7:0] rd, rr, imm, io, fl,
      input logic [2:0] b, input logic [15:0] pc, input logic [6:0] k, input logic two,
      output int n, output logic [15:0] npc, output logic tk, output logic cmp,
      output logic [7:0] nf);
      int a, s, c, r, sr;
      logic cond;
      cond = 1'b0;
      cmp = (op == 5'h01) || (op == 5'h02) || (op == 5'h03);
      case (op)
         5'h00: cond = (rd == rr);
         5'h04: cond = !rr[b];
         5'h05: cond = rr[b];
         5'h06: cond = !io[b];
         5'h07: cond = io[b];
         5'h08: cond = fl[b];
         5'h09: cond = !fl[b];
         5'h0A: cond = fl[1];
         5'h0B: cond = !fl[1];
         5'h0C, 5'h0F: cond = fl[0];
         5'h0D, 5'h0E: cond = !fl[0];
         5'h10: cond = fl[2];
         5'h11: cond = !fl[2];
         5'h12: cond = !(fl[2] ^ fl[3]);
         5'h13: cond = fl[2] ^ fl[3];
         5'h14: cond = fl[5];
         5'h15: cond = !fl[5];
         5'h16: cond = fl[6];
         5'h17: cond = !fl[6];
         5'h18: cond = fl[3];
         5'h19: cond = !fl[3];
         default: cond = 1'b0;
      endcase
      // subtraction without writeback, s t i kept
      a = rd;
      s = (op == 5'h03) ? imm : rr;
      c = (op == 5'h02) ? fl[0] : 0;
      r = a - s - c;
      sr = (a > 127 ? a - 256 : a) - (s > 127 ? s - 256 : s) - c;
      nf = fl;
      nf[0] = r < 0;
      nf[1] = ((r & 255) == 0) && ((op != 5'h02) || fl[1]);
      nf[2] = r[7];
      nf[3] = (sr > 127) || (sr < -128);
      nf[5] = ((a & 15) - (s & 15) - c) < 0;
      tk = cond;
      n = cond ? ((op <= 5'h07 && two) ? 3 : 2) : 1;
      npc = pc + 16'h0001;
      if (cond && op <= 5'h07) npc = pc + (two ? 16'h0003 : 16'h0002);
      if (cond && op > 5'h07) npc = pc + {{9{k[6]}}, k} + 16'h0001;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // input driver, non-blocking at the edge
   task automatic put(input logic [4:0] op, input logic [7:0] rd, rr, imm, io, fl,
      input logic [2:0] b, input logic [15:0] pc, input logic [6:0] k, input logic two);
      op_i <= csb_op_type'(op);
      rd_i <= rd;
      rr_i <= rr;
      imm_i <= imm;
      io_val_i <= io;
      flags_i <= fl;
      bit_sel_i <= b;
      pc_i <= pc;
      k_i <= k;
      next_two_word_i <= two;
   endtask

   // one instruction; start held so refused starts see flipped inputs while busy
   task automatic run_op(input logic [4:0] op);
      logic [31:0] w1, w2, w3;
      logic [15:0] npc;
      logic [7:0] nf, ef, rr, imm;
      logic tk, cmp;
      int n;
      w1 = rnd();
      w2 = rnd();
      w3 = rnd();
      rr = w3[8] ? w1[7:0] : w1[15:8];
      imm = w3[9] ? w1[7:0] : w1[23:16];
      model(op, w1[7:0], rr, imm, w1[31:24], w2[7:0], w2[10:8], w2[31:16], w3[6:0],
         w3[7], n, npc, tk, cmp, nf);
      ef = cmp ? nf : exp_flags;
      exp_flags = ef;
      put(op, w1[7:0], rr, imm, w1[31:24], w2[7:0], w2[10:8], w2[31:16], w3[6:0], w3[7]);
      start_i <= 1'b1;
      for (int j = 1; j < n; j++) begin
         @(posedge mclk_i);
         if (j == 1) put(w3[31:27], ~w1[7:0], ~rr, ~imm, ~w1[31:24], ~w2[7:0], ~w2[10:8],
            ~w2[31:16], ~w3[6:0], ~w3[7]);
         #1;
         chk_bit("busy_o", 1'b1, busy_o);
         chk_bit("done_o", 1'b0, done_o);
      end
      @(posedge mclk_i);
      fork
         begin
            #1;
            chk_bit("done_o", 1'b1, done_o);
            chk_bit("busy_o", 1'b0, busy_o);
            chk_val("pc_o", npc, pc_o);
            chk_bit("taken_o", tk, taken_o);
            chk_bit("flags_we_o", cmp, flags_we_o);
            chk_val("flags_o", {8'h00, ef}, {8'h00, flags_o});
         end
      join_none
   endtask

   // every op code, unused ones too, then idle
   task automatic burst(input int reps);
      for (int i = 0; i < reps * 32; i++) run_op(i[4:0]);
      start_i <= 1'b0;
      @(posedge mclk_i);
      #1;
      chk_bit("done_o", 1'b0, done_o);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // verdict and end of run
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // 4 ns clock
   initial begin
      mclk_i = 1'b0;
      forever #2 mclk_i = ~mclk_i;
   end

   // watchdog, run needs well under 3000 cycles
   initial begin
      #40000;
      n_mismatch++;
      print_verdict();
   end

   // reset, bursts, mid-run reset
   initial begin
      rst_i = 1'b1;
      start_i = 1'b0;
      put(5'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 3'h0, 16'h0000, 7'h00, 1'b0);
      repeat (5) @(posedge mclk_i);
      chk_rst();
      rst_i <= 1'b0;
      burst(10);
      @(posedge mclk_i);
      rst_i <= 1'b1;
      #1;
      chk_rst();
      @(posedge mclk_i);
      rst_i <= 1'b0;
      exp_flags = 8'h00;
      burst(2);
      print_verdict();
   end

endmodule
